// ===== core/scsfw_top.sv
// top: system clock selection, prescaler control, flash wait states and flash operation timing
//
// How it works
// [RULE_01] select 11 drives the system clock straight from the external clock input
// [RULE_02] select 10 with bypass 1 divides the oscillator by the prescaler factor
// [RULE_03] prescaler factor is divider field plus one; factor one passes oscillator through
// [RULE_04] prescaler divides by up to 1024, the slowest reachable system clock
// [RULE_05] software sets wait states 1/2/3/4 for up to 8/13/17 MHz and above
// [RULE_06] wait states delay only non-sequential reads; sequential reads use prefetch
// [RULE_07] software never erases or programs the module it is reading from
// [RULE_08] module 3 may be erased or programmed while any other module is read
// [RULE_09] at most four parallel operations at one read module and 80 MHz, else one; the code starts no operation while one is busy
// [RULE_10] each operation adds a few clock cycles beyond its 8.0 or 3.5 ms time
// [RULE_11] select 10 with bypass 0 takes the system clock from the loop output
// [RULE_12] select 00 takes the system clock from the wakeup clock source
// [RULE_13] reserved select 01 keeps the source that is currently active
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module scsfw_top #(
  parameter int unsigned ERASE_CYCLES   = scsfw_pkg::ERASE_CYC,
  parameter int unsigned PROGRAM_CYCLES = scsfw_pkg::PROGRAM_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clk_i,
  input  wire logic        crystal_i,
  input  wire logic        loop_clk_i,
  input  wire logic        wakeup_clk_i,
  input  wire logic        rd_req_i,
  input  wire logic        rd_seq_i,
  input  wire logic [1:0]  rd_module_i,
  output logic             sys_clk_o,
  output logic             rd_ready_o,
  output logic             op_busy_o,
  output logic             op_done_o
);

  // ==========================================================================
  // source synchronisers
  // ==========================================================================
  logic [scsfw_pkg::NSRC-1:0] src_raw;
  logic [scsfw_pkg::NSRC-1:0] src_meta_q;
  logic [scsfw_pkg::NSRC-1:0] src_sync_q;

  assign src_raw = {wakeup_clk_i, loop_clk_i, crystal_i, ext_clk_i};

  // two flip-flops per clock source pin
  genvar gi;
  generate
    for (gi = 0; gi < scsfw_pkg::NSRC; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          src_meta_q[gi] <= 1'b0;
          src_sync_q[gi] <= 1'b0;
        end else begin
          src_meta_q[gi] <= src_raw[gi];
          src_sync_q[gi] <= src_meta_q[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // register state
  // ==========================================================================
  scsfw_pkg::scsfw_sel_t sel_q;
  scsfw_pkg::scsfw_sel_t sel_d;
  scsfw_pkg::scsfw_sel_t active_q;
  scsfw_pkg::scsfw_sel_t active_d;
  logic                  byp_q;
  logic                  byp_d;
  scsfw_pkg::scsfw_div_t div_q;
  scsfw_pkg::scsfw_div_t div_d;
  scsfw_pkg::scsfw_ws_t  ws_q;
  scsfw_pkg::scsfw_ws_t  ws_d;
  logic                  refused_q;
  logic                  refused_d;
  logic                  ack_q;
  logic                  ack_d;
  logic [31:0]           dat_q;
  logic [31:0]           dat_d;

  // bus decode
  logic                  wb_hit;
  logic                  wb_wr;
  logic [31:0]           wmask;
  logic [31:0]           rdata;
  logic [31:0]           cur_sysctl;
  logic [31:0]           cur_loopctl;
  logic [31:0]           cur_membus;
  logic [31:0]           cur_flcmd;
  logic [31:0]           new_word;

  // flash operation command decode
  logic                  start_req;
  logic                  start_ok;
  logic                  conflict;
  logic                  refused_clr;
  logic                  rd_active;
  scsfw_pkg::scsfw_mod_t tgt_new;

  // flash operation sequencer
  scsfw_pkg::scsfw_op_e   op_q;
  scsfw_pkg::scsfw_op_e   op_d;
  scsfw_pkg::scsfw_opcnt_t op_cnt_q;
  scsfw_pkg::scsfw_opcnt_t op_cnt_d;
  logic                  kind_q;
  logic                  kind_d;
  scsfw_pkg::scsfw_mod_t tgt_q;
  scsfw_pkg::scsfw_mod_t tgt_d;
  logic                  busy_q;
  logic                  busy_d;
  logic                  done_q;
  logic                  done_d;

  // flash read timing
  logic                  rd_busy_q;
  logic                  rd_busy_d;
  scsfw_pkg::scsfw_ws_t  rd_cnt_q;
  scsfw_pkg::scsfw_ws_t  rd_cnt_d;
  logic                  rd_ready_q;
  logic                  rd_ready_d;

  // system clock
  logic                  sys_clk_q;
  logic                  sys_clk_d;

  scsfw_div_if div_bus ();

  // ==========================================================================
  // prescaler
  // ==========================================================================
  assign div_bus.osc_lvl = src_sync_q[scsfw_pkg::SRC_XTAL];
  assign div_bus.factor  = {1'b0, div_q} + 11'h001;  // factor is field plus one [RULE_03]

  scsfw_prescaler u_prescaler (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .div_if (div_bus)
  );

  // ==========================================================================
  // wishbone slave
  // ==========================================================================
  assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr  = wb_hit && wb_we_i;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // current register words as software sees them
  always_comb begin
    cur_sysctl  = 32'h0000_0000;
    cur_loopctl = 32'h0000_0000;
    cur_membus  = 32'h0000_0000;
    cur_flcmd   = 32'h0000_0000;
    cur_sysctl[scsfw_pkg::SEL_LSB +: scsfw_pkg::SEL_W]      = sel_q;
    cur_sysctl[scsfw_pkg::ACT_LSB +: scsfw_pkg::SEL_W]      = active_q;
    cur_loopctl[scsfw_pkg::BYP_BIT]                         = byp_q;
    cur_loopctl[scsfw_pkg::DIV_LSB +: scsfw_pkg::DIV_W]     = div_q;
    cur_membus[scsfw_pkg::WS_LSB +: scsfw_pkg::WS_W]        = ws_q;
    cur_flcmd[scsfw_pkg::CMD_KIND]                          = kind_q;
    cur_flcmd[scsfw_pkg::CMD_TGT_LSB +: scsfw_pkg::MOD_W]   = tgt_q;
    cur_flcmd[scsfw_pkg::CMD_BUSY]                          = busy_q;
    cur_flcmd[scsfw_pkg::CMD_REFUSED]                       = refused_q;
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (wb_adr_i)
      scsfw_pkg::ADR_SYSCTL:  rdata = cur_sysctl;
      scsfw_pkg::ADR_LOOPCTL: rdata = cur_loopctl;
      scsfw_pkg::ADR_MEMBUS:  rdata = cur_membus;
      scsfw_pkg::ADR_FLCMD:   rdata = cur_flcmd;
      default:                rdata = 32'h0000_0000;
    endcase
  end

  // write data masked by byte lanes, used by every write decode
  assign new_word = (wb_dat_i & wmask);

  // configuration register updates and bus answer
  always_comb begin
    ack_d = wb_hit;
    dat_d = (wb_hit && !wb_we_i) ? rdata : 32'h0000_0000;
    sel_d = sel_q;
    byp_d = byp_q;
    div_d = div_q;
    ws_d  = ws_q;
    if (wb_wr && wb_adr_i == scsfw_pkg::ADR_SYSCTL && wb_sel_i[0]) begin
      sel_d = new_word[scsfw_pkg::SEL_LSB +: scsfw_pkg::SEL_W];
    end
    if (wb_wr && wb_adr_i == scsfw_pkg::ADR_LOOPCTL) begin
      if (wb_sel_i[0]) begin
        byp_d = new_word[scsfw_pkg::BYP_BIT];
      end
      if (wb_sel_i[2]) begin
        div_d[7:0] = new_word[scsfw_pkg::DIV_LSB +: 8];
      end
      if (wb_sel_i[3]) begin
        div_d[9:8] = new_word[scsfw_pkg::DIV_LSB + 8 +: 2];
      end
    end
    if (wb_wr && wb_adr_i == scsfw_pkg::ADR_MEMBUS && wb_sel_i[0]) begin
      ws_d = new_word[scsfw_pkg::WS_LSB +: scsfw_pkg::WS_W];  // software picks the count [RULE_05]
    end
  end

  // ==========================================================================
  // flash operation command
  // ==========================================================================
  assign tgt_new     = new_word[scsfw_pkg::CMD_TGT_LSB +: scsfw_pkg::MOD_W];
  assign start_req   = wb_wr && wb_adr_i == scsfw_pkg::ADR_FLCMD && wb_sel_i[0] &&
                       new_word[scsfw_pkg::CMD_START];
  assign refused_clr = wb_wr && wb_adr_i == scsfw_pkg::ADR_FLCMD && wb_sel_i[1] &&
                       new_word[scsfw_pkg::CMD_REFUSED];
  assign rd_active   = rd_busy_q || rd_req_i;
  // only the module being read is blocked, so module 3 runs beside any other read [RULE_07] [RULE_08]
  assign conflict    = rd_active && (tgt_new == rd_module_i);
  assign start_ok    = start_req && !busy_q && !conflict;

  // refused flag: a new refusal wins over a clear in the same cycle
  always_comb begin
    refused_d = (start_req && !start_ok) || (refused_q && !refused_clr);
  end

  // erase or program sequencer: timed part then overhead cycles
  always_comb begin
    op_d     = op_q;
    op_cnt_d = op_cnt_q;
    kind_d   = kind_q;
    tgt_d    = tgt_q;
    done_d   = 1'b0;
    case (op_q)
      scsfw_pkg::OP_IDLE: begin
        if (start_ok) begin
          op_d   = scsfw_pkg::OP_TIMED;
          kind_d = new_word[scsfw_pkg::CMD_KIND];
          tgt_d  = tgt_new;
          if (new_word[scsfw_pkg::CMD_KIND]) begin
            op_cnt_d = scsfw_pkg::scsfw_opcnt_t'(PROGRAM_CYCLES - 1);
          end else begin
            op_cnt_d = scsfw_pkg::scsfw_opcnt_t'(ERASE_CYCLES - 1);
          end
        end
      end
      scsfw_pkg::OP_TIMED: begin
        if (op_cnt_q == 20'h00000) begin
          op_d     = scsfw_pkg::OP_FINISH;
          op_cnt_d = scsfw_pkg::scsfw_opcnt_t'(scsfw_pkg::OP_EXTRA_CYC - 1);  // extra cycles [RULE_10]
        end else begin
          op_cnt_d = op_cnt_q - 20'h00001;
        end
      end
      scsfw_pkg::OP_FINISH: begin
        if (op_cnt_q == 20'h00000) begin
          op_d   = scsfw_pkg::OP_IDLE;
          done_d = 1'b1;
        end else begin
          op_cnt_d = op_cnt_q - 20'h00001;  // [RULE_10]
        end
      end
      default: begin
        op_d     = scsfw_pkg::OP_IDLE;
        op_cnt_d = 20'h00000;
      end
    endcase
    busy_d = (op_d != scsfw_pkg::OP_IDLE);
  end

  // ==========================================================================
  // flash read wait states
  // ==========================================================================
  always_comb begin
    rd_busy_d  = rd_busy_q;
    rd_cnt_d   = rd_cnt_q;
    rd_ready_d = 1'b0;
    if (!rd_busy_q) begin
      if (rd_req_i) begin
        rd_busy_d = 1'b1;
        rd_cnt_d  = rd_seq_i ? 4'h0 : ws_q;  // waits only on non-sequential reads [RULE_06]
      end
    end else if (rd_cnt_q == 4'h0) begin
      rd_busy_d  = 1'b0;
      rd_ready_d = 1'b1;
    end else begin
      rd_cnt_d = rd_cnt_q - 4'h1;
    end
  end

  // ==========================================================================
  // system clock selection
  // ==========================================================================
  always_comb begin
    active_d  = (sel_q == scsfw_pkg::SEL_RSVD) ? active_q : sel_q;  // reserved keeps source [RULE_13]
    sys_clk_d = sys_clk_q;
    case (active_q)
      scsfw_pkg::SEL_DIRECT: sys_clk_d = src_sync_q[scsfw_pkg::SRC_EXT];  // [RULE_01]
      scsfw_pkg::SEL_LOOP: begin
        if (byp_q) begin
          sys_clk_d = div_bus.div_clk;  // prescaler path [RULE_02]
        end else begin
          sys_clk_d = src_sync_q[scsfw_pkg::SRC_LOOP];  // [RULE_11]
        end
      end
      scsfw_pkg::SEL_WAKEUP: sys_clk_d = src_sync_q[scsfw_pkg::SRC_WAKE];  // [RULE_12]
      default:               sys_clk_d = sys_clk_q;
    endcase
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q      <= scsfw_pkg::SEL_RST;
      active_q   <= scsfw_pkg::SEL_RST;
      byp_q      <= scsfw_pkg::BYP_RST;
      div_q      <= scsfw_pkg::DIV_RST;
      ws_q       <= scsfw_pkg::WS_RST;
      refused_q  <= 1'b0;
      ack_q      <= 1'b0;
      dat_q      <= 32'h0000_0000;
      op_q       <= scsfw_pkg::OP_IDLE;
      op_cnt_q   <= 20'h00000;
      kind_q     <= 1'b0;
      tgt_q      <= 2'h0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      rd_busy_q  <= 1'b0;
      rd_cnt_q   <= 4'h0;
      rd_ready_q <= 1'b0;
      sys_clk_q  <= 1'b0;
    end else begin
      sel_q      <= sel_d;
      active_q   <= active_d;
      byp_q      <= byp_d;
      div_q      <= div_d;
      ws_q       <= ws_d;
      refused_q  <= refused_d;
      ack_q      <= ack_d;
      dat_q      <= dat_d;
      op_q       <= op_d;
      op_cnt_q   <= op_cnt_d;
      kind_q     <= kind_d;
      tgt_q      <= tgt_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      rd_busy_q  <= rd_busy_d;
      rd_cnt_q   <= rd_cnt_d;
      rd_ready_q <= rd_ready_d;
      sys_clk_q  <= sys_clk_d;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o   = dat_q;
  assign wb_ack_o   = ack_q;
  assign sys_clk_o  = sys_clk_q;
  assign rd_ready_o = rd_ready_q;
  assign op_busy_o  = busy_q;
  assign op_done_o  = done_q;

endmodule

// ===== core/scsfw_pkg.sv
// package: register map, field layout, reset values and timing counts of the clock select block
package scsfw_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS   = 20;    // 50 MHz system side clock
  localparam real         ERASE_TIME_MS   = 8.0;   // longest sector or page erase
  localparam real         PROGRAM_TIME_MS = 3.5;   // longest page program
  // longest times round down to whole cycles
  localparam int unsigned ERASE_CYC   = $rtoi(ERASE_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS));
  localparam int unsigned PROGRAM_CYC = $rtoi(PROGRAM_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS));
  localparam int unsigned OP_EXTRA_CYC = 4;        // control state machine overhead

  // ==========================================================================
  // types
  // ==========================================================================
  typedef logic [19:0] scsfw_opcnt_t;
  typedef logic [10:0] scsfw_fact_t;
  typedef logic [9:0]  scsfw_div_t;
  typedef logic [3:0]  scsfw_ws_t;
  typedef logic [1:0]  scsfw_sel_t;
  typedef logic [1:0]  scsfw_mod_t;
  typedef enum logic [1:0] {OP_IDLE, OP_TIMED, OP_FINISH} scsfw_op_e;

  // ==========================================================================
  // register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADR_SYSCTL  = 8'h00;  // system_control_word0
  localparam logic [7:0] ADR_LOOPCTL = 8'h04;  // loop_control_word0
  localparam logic [7:0] ADR_MEMBUS  = 8'h08;  // memory_bus_control
  localparam logic [7:0] ADR_FLCMD   = 8'h0c;  // flash operation command and status

  // ==========================================================================
  // field positions and widths
  // ==========================================================================
  localparam int unsigned SEL_LSB     = 0;   // clock_source_select
  localparam int unsigned ACT_LSB     = 4;   // active source, read only
  localparam int unsigned BYP_BIT     = 0;   // vco_bypass_bit
  localparam int unsigned DIV_LSB     = 16;  // output_prescaler_divider
  localparam int unsigned WS_LSB      = 0;   // flash_wait_state_count
  localparam int unsigned CMD_START   = 0;
  localparam int unsigned CMD_KIND    = 1;   // 0 erase, 1 program
  localparam int unsigned CMD_TGT_LSB = 4;
  localparam int unsigned CMD_BUSY    = 8;
  localparam int unsigned CMD_REFUSED = 9;
  localparam int unsigned SEL_W       = 2;
  localparam int unsigned DIV_W       = 10;
  localparam int unsigned WS_W        = 4;
  localparam int unsigned MOD_W       = 2;

  // ==========================================================================
  // reset values and codes
  // ==========================================================================
  localparam scsfw_sel_t SEL_RST    = 2'h0;
  localparam logic       BYP_RST    = 1'h1;
  localparam scsfw_div_t DIV_RST    = 10'h000;
  localparam scsfw_ws_t  WS_RST     = 4'h4;
  localparam scsfw_sel_t SEL_WAKEUP = 2'h0;
  localparam scsfw_sel_t SEL_RSVD   = 2'h1;
  localparam scsfw_sel_t SEL_LOOP   = 2'h2;
  localparam scsfw_sel_t SEL_DIRECT = 2'h3;
  localparam scsfw_mod_t MOD_FREE   = 2'h3;  // module usable beside a read of any other module
  localparam int unsigned SRC_EXT   = 0;
  localparam int unsigned SRC_XTAL  = 1;
  localparam int unsigned SRC_LOOP  = 2;
  localparam int unsigned SRC_WAKE  = 3;
  localparam int unsigned NSRC      = 4;

endpackage

// ===== core/scsfw_div_if.sv
// interface: oscillator level, prescaler factor and divided clock between top and prescaler
`timescale 1ns/1ps
interface scsfw_div_if;
  logic                   osc_lvl;
  scsfw_pkg::scsfw_fact_t factor;
  logic                   div_clk;

  modport top (output osc_lvl, output factor, input div_clk);
  modport div (input osc_lvl, input factor, output div_clk);
endinterface

// ===== core/scsfw_prescaler.sv
// output prescaler: divides the synchronised oscillator level by a factor of 1 to 1024
`timescale 1ns/1ps
module scsfw_prescaler (
  input  wire logic clk_i,
  input  wire logic rst_i,
  scsfw_div_if.div  div_if
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic                   prev_q;
  logic                   prev_d;
  scsfw_pkg::scsfw_div_t  cnt_q;
  scsfw_pkg::scsfw_div_t  cnt_d;
  logic                   out_q;
  logic                   out_d;
  scsfw_pkg::scsfw_fact_t half;
  scsfw_pkg::scsfw_fact_t last;

  assign div_if.div_clk = out_q;
  assign half           = (div_if.factor + 11'h001) >> 1;
  assign last           = div_if.factor - 11'h001;

  // next count and output level, stepping on each oscillator rise
  always_comb begin
    prev_d = div_if.osc_lvl;
    cnt_d  = cnt_q;
    out_d  = out_q;
    if (div_if.factor == 11'h001) begin
      out_d = div_if.osc_lvl;  // pass-through keeps oscillator duty [RULE_03]
      cnt_d = 10'h000;
    end else if (div_if.osc_lvl && !prev_q) begin
      if ({1'b0, cnt_q} >= last) begin
        cnt_d = 10'h000;  // one output period per factor rises [RULE_02]
      end else begin
        cnt_d = cnt_q + 10'h001;
      end
      out_d = ({1'b0, cnt_d} < half);  // high for the first half of the period [RULE_04]
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      cnt_q  <= 10'h000;
      out_q  <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      out_q  <= out_d;
    end
  end

endmodule

// ===== dv/scsfw_monitor.sv
// checker: port-level properties of the clock select block
`timescale 1ns/1ps
module scsfw_monitor #(
  parameter int unsigned ERASE_CYCLES   = 20,
  parameter int unsigned PROGRAM_CYCLES = 10
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        ext_clk_i,
  input wire logic        loop_clk_i,
  input wire logic        wakeup_clk_i,
  input wire logic        rd_req_i,
  input wire logic        rd_seq_i,
  input wire logic        sys_clk_o,
  input wire logic        rd_ready_o,
  input wire logic        op_busy_o,
  input wire logic        op_done_o
);
  // ======================
  // shadow of source, bypass, settle time and busy length
  logic [1:0]  act_q, act_d;
  logic        byp_q, byp_d;
  logic [3:0]  st_q, st_d;
  logic [19:0] bc_q, bc_d;
  logic        tk;
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
  // reserved code 01 leaves the shadow source alone
  always_comb begin
    act_d = act_q;
    byp_d = byp_q;
    st_d  = (st_q == 4'hf) ? st_q : st_q + 4'h1;
    bc_d  = op_busy_o ? bc_q + 20'h1 : 20'h0;
    if (tk && wb_adr_i == 8'h00 && wb_dat_i[1:0] != 2'h1) begin
      act_d = wb_dat_i[1:0];
      st_d  = 4'h0;
    end
    if (tk && wb_adr_i == 8'h04) begin
      byp_d = wb_dat_i[0];
      st_d  = 4'h0;
    end
  end
  // registers of the shadow state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_q <= 2'h0;
      byp_q <= 1'h1;
      st_q  <= 4'h0;
      bc_q  <= 20'h0;
    end else begin
      act_q <= act_d;
      byp_q <= byp_d;
      st_q  <= st_d;
      bc_q  <= bc_d;
    end
  end
  // ======================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_DIRECT: assert property (act_q == 2'h3 && st_q > 4'h5 |-> sys_clk_o == $past(ext_clk_i, 3))
    else $error("system clock not following direct input");
  AST_WAKE: assert property (act_q == 2'h0 && st_q > 4'h5 |-> sys_clk_o == $past(wakeup_clk_i, 3))
    else $error("system clock not following wakeup source");
  AST_LOOP: assert property (act_q == 2'h2 && !byp_q && st_q > 4'h5 |-> sys_clk_o == $past(loop_clk_i, 3))
    else $error("system clock not following loop output");
  AST_SEQ: assert property (rd_ready_o && rd_req_i && rd_seq_i |=> !rd_ready_o ##1 rd_ready_o)
    else $error("sequential read not served in two cycles");
  AST_RDY_PULSE: assert property (rd_ready_o |=> !rd_ready_o)
    else $error("read ready longer than one cycle");
  AST_BUSY_LEN: assert property ($fell(op_busy_o) |-> bc_q == ERASE_CYCLES + scsfw_pkg::OP_EXTRA_CYC
    || bc_q == PROGRAM_CYCLES + scsfw_pkg::OP_EXTRA_CYC) else $error("operation length wrong");
  AST_DONE_FALL: assert property (op_done_o |-> $fell(op_busy_o))
    else $error("done without end of busy");
  AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");
endmodule

bind scsfw_top scsfw_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES)) u_mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .ext_clk_i,
  .loop_clk_i, .wakeup_clk_i, .rd_req_i, .rd_seq_i, .sys_clk_o, .rd_ready_o, .op_busy_o, .op_done_o);

// ===== dv/scsfw_clk_src.sv
// model: free-running clock sources at the block's far side
`timescale 1ns/1ps
module scsfw_clk_src (
  output logic ext_clk_o,
  output logic crystal_o,
  output logic loop_clk_o,
  output logic wakeup_clk_o
);
  // ======================
  // sources
  // half periods are multiples of 20 ns, so no edge meets a system clock rise
  initial begin
    ext_clk_o    = 1'b0;
    crystal_o    = 1'b0;
    loop_clk_o   = 1'b0;
    wakeup_clk_o = 1'b0;
  end
  always #100 ext_clk_o = ~ext_clk_o;
  always #60 crystal_o = ~crystal_o;
  always #140 loop_clk_o = ~loop_clk_o;
  always #220 wakeup_clk_o = ~wakeup_clk_o;
endmodule

// ===== dv/test_system_clock_select_and_flash_waits.sv
// bench: self-checking test of the clock select block
`timescale 1ns/1ps
module test_system_clock_select_and_flash_waits;
  localparam int EC = 20;
  localparam int PC = 10;
  logic        clk_i, rst_i, cyc, stb, we, ack, rd_req, rd_seq, sys_clk, rdy, busy, done;
  logic        ext, xtal, lpc, wake;
  logic [7:0]  adr;
  logic [3:0]  sel, h1, h2, h3;
  logic [31:0] wdat, rdat, x;
  logic [1:0]  rd_mod;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc_cnt = 0;

  scsfw_top #(.ERASE_CYCLES(EC), .PROGRAM_CYCLES(PC)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_clk_i(ext), .crystal_i(xtal),
    .loop_clk_i(lpc), .wakeup_clk_i(wake), .rd_req_i(rd_req), .rd_seq_i(rd_seq), .rd_module_i(rd_mod),
    .sys_clk_o(sys_clk), .rd_ready_o(rdy), .op_busy_o(busy), .op_done_o(done));
  scsfw_clk_src u_src (.ext_clk_o(ext), .crystal_o(xtal), .loop_clk_o(lpc), .wakeup_clk_o(wake));

  // ======================
  // clock, delayed source copies and hang guard
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    h1 <= {wake, lpc, xtal, ext};
    h2 <= h1;
    h3 <= h2;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      bad_count++;
      conclude();
    end
  end

  // ======================
  // shared tasks
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    x = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(w, e, x);
  endtask
  task automatic follow(input string w, input int i);
    int errs = 0;
    repeat (8) @(posedge clk_i);
    repeat (60) begin
      @(negedge clk_i);
      if (sys_clk !== h3[i]) errs++;
    end
    chk(w, 32'h0, 32'(errs));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ======================
  // scenarios
  task automatic t_select();
    wb(1'b1, 8'h04, 4'h1, 32'h0);
    wb(1'b1, 8'h00, 4'h1, 32'h3);
    follow("direct", 0);
    wb(1'b1, 8'h00, 4'h1, 32'h1);
    follow("reserved", 0);
    rdc("select", 8'h00, 32'h31);
    wb(1'b1, 8'h00, 4'h1, 32'h0);
    follow("wakeup", 3);
    wb(1'b1, 8'h00, 4'h1, 32'h2);
    follow("loop", 2);
    $display("select test done");
  endtask
  task automatic t_presc(input logic [9:0] dv);
    longint t0;
    wb(1'b1, 8'h04, 4'hd, {6'h0, dv, 15'h0, 1'b1});
    @(posedge sys_clk);
    @(posedge sys_clk);
    t0 = $time;
    @(posedge sys_clk);
    chk("period", 32'(120 * (int'(dv) + 1)), 32'($time - t0));
    $display("prescaler test done");
  endtask
  task automatic rd_lat(input logic s, input logic [3:0] ws, input logic [31:0] e);
    int n = 0;
    wb(1'b1, 8'h08, 4'h1, {28'h0, ws});
    @(posedge clk_i);
    rd_req <= 1'b1;
    rd_seq <= s;
    @(posedge clk_i);
    rd_req <= 1'b0;
    while (rdy !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("read latency", e, 32'(n));
    $display("read test done");
  endtask
  task automatic t_op(input logic k, input logic [1:0] t, input logic [1:0] m, input logic [31:0] e);
    int n = 0;
    rd_mod <= m;
    rd_req <= 1'b1;
    rd_seq <= 1'b1;
    wb(1'b1, 8'h0c, 4'h1, {26'h0, t, 2'h0, k, 1'b1});
    rd_req <= 1'b0;
    while (busy === 1'b1) begin
      n++;
      @(posedge clk_i);
    end
    chk("busy cycles", e, 32'(n));
    chk("done", 32'(e != 0), {31'h0, done});
    $display("operation test done");
  endtask

  // ======================
  // main sequence
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    rd_req = 1'b0;
    rd_seq = 1'b0;
    rd_mod = 2'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("bypass", 8'h04, 32'h1);
    rdc("waits", 8'h08, 32'h4);
    wb(1'b1, 8'h08, 4'h0, 32'h2);
    rdc("waits masked", 8'h08, 32'h4);
    wb(1'b1, 8'h10, 4'hf, 32'hffffffff);
    rdc("unmapped", 8'h10, 32'h0);
    t_select();
    t_presc(10'h000);
    t_presc(10'h002);
    t_presc(10'h3ff);
    for (int w = 1; w <= 4; w++) rd_lat(1'b0, 4'(w), 32'(w + 2));
    rd_lat(1'b1, 4'h4, 32'h2);
    t_op(1'b0, 2'h3, 2'h0, EC + 4);
    t_op(1'b1, 2'h0, 2'h3, PC + 4);
    t_op(1'b0, 2'h1, 2'h1, 32'h0);
    rdc("refused", 8'h0c, 32'h202);
    wb(1'b1, 8'h0c, 4'h2, 32'h200);
    rdc("cleared", 8'h0c, 32'h2);
    conclude();
  end
endmodule
